// File: src/buck_fault_sequencer.sv
`include "buck_seq_params.svh"
`default_nettype none
// How it works
// RULE1: soft start charges only with supply above turn-on and enable high
// RULE2: output ok low in soft start; released on reaching run
// RULE3: over and under voltage are ORed into output ok and latch
// RULE4: active shutdown latch forces high gate off, low gate on
// RULE5: outside window output ok drops and gates go high off, low on
// RULE6: output ok never latches; high again inside the window
// RULE7: lockout below lower threshold forces gates until turn-on again
// RULE8: lockout discharges the soft-start node
// RULE9: current limit judged only while the low side is on
// RULE10: current limit holds high off, low on while it lasts
// RULE11: current limit sinks the soft-start node
// RULE12: duty is capped by the soft-start level
// RULE13: current sense ignored around the high to low swap
// RULE14: latching variant holds fault until shutdown pulses low
// RULE15: under voltage masked only during the first soft start
// RULE16: non-latching variant resumes once the fault clears
// RULE17: shutdown low discharges soft start and forces the gates
// RULE18: normal run drives complementary gates at the set duty
// RULE19: period settable for 50 kHz to 2 MHz switching
// RULE20: inputs synchronised; faults outrank regulation
module buck_fault_sequencer
    import buck_seq_pkg::*;
#(
    parameter int PW = 10
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        supply_above_on,
    input  wire logic        supply_below_off,
    input  wire logic        enable_input,
    input  wire logic        shutdown_n_input,
    input  wire logic        over_voltage_protect,
    input  wire logic        under_voltage_protect,
    input  wire logic        current_sense_input,
    input  wire logic        ss_level_reached,
    output logic             high_side_gate_cmd,
    output logic             low_side_gate_cmd,
    output logic             ss_charge,
    output logic             ss_discharge,
    output logic             ss_sink,
    output logic             output_ok_flag,
    output logic             output_ok_pull_oe
);
    generate
        if (PW < $clog2(`PER_MAX + 1))
            $error("PW too small for the longest period");
    endgenerate

    cmp_type       cmp_raw;
    cmp_type       cmp_meta_r;
    cmp_type       cmp_r;
    seq_state_type state_r;
    seq_state_type state_nxt;
    logic          lockout_r;
    logic          first_r;
    logic          cl_r;
    logic          latch_mode_r;
    logic [PW-1:0] period_r;
    logic [PW-1:0] duty_r;
    logic [PW-1:0] ss_lvl_r;
    logic [PW-1:0] duty_eff;
    logic          on_req;
    logic          active;
    logic          uv_mask;
    logic          fault;
    logic          force_low;
    logic          pwm_hs;
    logic          pwm_start;
    logic          pwm_blank;
    logic          addr_ok;
    logic          wr_pend_r;
    logic [7:0]    wr_addr_r;
    logic [31:0]   rd_mux;
    logic [PW-1:0] wr_period;

    assign cmp_raw = '{supply_on:  supply_above_on,
                       supply_low: supply_below_off,
                       enable:     enable_input,
                       shutdown_n: shutdown_n_input,
                       over_v:     over_voltage_protect,
                       under_v:    under_voltage_protect,
                       cs_over:    current_sense_input,
                       ss_full:    ss_level_reached};

    // RULE20: two-stage input sync
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_meta_r <= '0;
            cmp_r      <= '0;
        end
        else
        begin
            cmp_meta_r <= cmp_raw;
            cmp_r      <= cmp_meta_r;
        end
    end

    // RULE7: hysteretic supply lockout
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lockout_r <= 1'b1;
        else if (cmp_r.supply_low)
            lockout_r <= 1'b1;
        else if (cmp_r.supply_on)
            lockout_r <= 1'b0;
    end

    assign on_req  = cmp_r.shutdown_n && cmp_r.enable;
    assign active  = (state_r == S_SOFT) || (state_r == S_RUN);
    // RULE15: under voltage ignored in the first ramp only
    assign uv_mask = first_r && (state_r == S_SOFT);
    // RULE3: the two window detections are ORed
    assign fault   = cmp_r.over_v || (cmp_r.under_v && !uv_mask);

    always_comb
    begin
        state_nxt = state_r;
        if (lockout_r)
            state_nxt = S_LOCK;
        else
            unique case (state_r)
                S_LOCK:
                    state_nxt = S_OFF;
                S_OFF:
                    // RULE1: start only when enabled out of lockout
                    if (on_req)
                        state_nxt = S_SOFT;
                S_SOFT:
                    if (!on_req)
                        state_nxt = S_OFF;
                    else if (fault && latch_mode_r)
                        state_nxt = S_LATCH;
                    else if (cmp_r.ss_full)
                        state_nxt = S_RUN;
                S_RUN:
                    // RULE17: shutdown low ends regulation
                    if (!on_req)
                        state_nxt = S_OFF;
                    // RULE14: latching variant stops on a fault
                    else if (fault && latch_mode_r)
                        state_nxt = S_LATCH;
                S_LATCH:
                    // RULE14: only a shutdown pulse or a supply lockout frees it
                    if (!cmp_r.shutdown_n)
                        state_nxt = S_OFF;
            endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_r <= S_LOCK;
        else
            state_r <= state_nxt;
    end

    // first ramp after power-up only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            first_r <= 1'b1;
        else if (state_r == S_SOFT && state_nxt == S_RUN)
            first_r <= 1'b0;
    end

    // RULE9: judged only with the low side on
    // RULE13: swap window blanked
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cl_r <= 1'b0;
        else if (!active)
            cl_r <= 1'b0;
        // held otherwise: a late high pulse must not drop the limit
        else if (low_side_gate_cmd && !pwm_blank)
            cl_r <= cmp_r.cs_over;
    end

    // RULE20: faults and limit outrank the modulator
    // RULE4: shutdown latch state forces the gates
    // RULE5: window fault turns high off, low on
    // RULE16: non-latching run resumes when fault clears
    // RULE10: limit holds high off for its whole length
    assign force_low = !active || fault || cl_r;

    // RULE12: soft-start level caps the duty
    assign duty_eff = (duty_r < ss_lvl_r) ? duty_r : ss_lvl_r;

    // RULE18: complementary switching at the set duty
    pwm_core #(
        .PW    (PW),
        .BLANK (`BLANK_CYC)
    ) u_pwm (
        .clk          (hclk),
        .rst_n        (hresetn),
        .run          (active),
        .force_low    (force_low),
        .period       (period_r),
        .duty         (duty_eff),
        .hs_on        (pwm_hs),
        .period_start (pwm_start),
        .blank        (pwm_blank)
    );

    // RULE7: idle states give high off, low on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            high_side_gate_cmd <= 1'b0;
            low_side_gate_cmd  <= 1'b1;
        end
        else
        begin
            high_side_gate_cmd <= pwm_hs;
            low_side_gate_cmd  <= !pwm_hs;
        end
    end

    // digital image of the ramp; one step per switching period
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ss_lvl_r <= '0;
        else if (!active)
            ss_lvl_r <= '0;
        else if (pwm_start && cl_r && ss_lvl_r != '0)
            ss_lvl_r <= ss_lvl_r - 1'b1;
        else if (pwm_start && !cl_r && ss_lvl_r < period_r)
            ss_lvl_r <= ss_lvl_r + 1'b1;
    end

    // RULE8: switch empties the node in lockout and off
    // RULE11: fixed sink while current limited
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ss_charge    <= 1'b0;
            ss_discharge <= 1'b1;
            ss_sink      <= 1'b0;
        end
        else
        begin
            ss_charge    <= (state_nxt == S_SOFT
                             || state_nxt == S_RUN) && !cl_r;
            ss_discharge <= !(state_nxt == S_SOFT
                              || state_nxt == S_RUN);
            ss_sink      <= cl_r;
        end
    end

    // RULE2: low through the ramp, up only in run
    // RULE6: follows the window, no memory
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            output_ok_flag    <= 1'b0;
            output_ok_pull_oe <= 1'b1;
        end
        else
        begin
            output_ok_flag    <= state_nxt == S_RUN
                                 && !cmp_r.over_v && !cmp_r.under_v;
            output_ok_pull_oe <= !(state_nxt == S_RUN
                                 && !cmp_r.over_v && !cmp_r.under_v);
        end
    end

    // bus slave: zero wait, always OKAY
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            `A_CTRL:   rd_mux[`CTRL_LATCH_BIT] = latch_mode_r;
            `A_PERIOD: rd_mux[PW-1:0] = period_r;
            `A_DUTY:   rd_mux[PW-1:0] = duty_r;
            `A_STATUS: rd_mux[7:0] = {state_r, lockout_r, cl_r,
                                      output_ok_flag, first_r, fault};
            default:   rd_mux = 32'h0000_0000;
        endcase
        if (haddr[31:8] != '0)
            rd_mux = 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= addr_ok && hwrite && haddr[31:8] == '0;
            wr_addr_r <= haddr[7:0];
            if (addr_ok && !hwrite)
                hrdata <= rd_mux;
        end
    end

    // RULE19: period kept inside the 50 kHz to 2 MHz span
    assign wr_period = (hwdata > `PER_MAX) ? PW'(`PER_MAX) :
                       (hwdata < `PER_MIN) ? PW'(`PER_MIN) :
                       hwdata[PW-1:0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            latch_mode_r <= 1'(`CTRL_RST);
            period_r     <= PW'(`PER_RST);
            duty_r       <= PW'(`DUTY_RST);
        end
        else if (wr_pend_r)
        begin
            if (wr_addr_r == `A_CTRL)
                latch_mode_r <= hwdata[`CTRL_LATCH_BIT];
            if (wr_addr_r == `A_PERIOD)
                period_r <= wr_period;
            if (wr_addr_r == `A_DUTY)
                duty_r <= (hwdata > 32'(`PER_MAX)) ?
                          PW'(`PER_MAX) : hwdata[PW-1:0];
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_start_needs_en: assert property ( // RULE1
        state_r == S_OFF ##1 state_r == S_SOFT
        |-> $past(on_req) && !$past(lockout_r))
        else $error("ramp began without enable");
    a_ramp_ok_low: assert property ( // RULE2
        state_r == S_SOFT |-> !output_ok_flag)
        else $error("output ok high during ramp");
    a_fault_ok_low: assert property ( // RULE3
        cmp_r.over_v || cmp_r.under_v |=> !output_ok_flag)
        else $error("output ok high during fault");
    a_latch_gates: assert property ( // RULE4
        (state_r == S_LATCH)[*3]
        |-> !high_side_gate_cmd && low_side_gate_cmd)
        else $error("gates not forced in latch");
    a_fault_gates: assert property ( // RULE5
        (fault && !cl_r)[*3] |-> !high_side_gate_cmd)
        else $error("high side on during fault");
    a_ok_window: assert property ( // RULE6
        state_nxt == S_RUN && !cmp_r.over_v && !cmp_r.under_v
        |=> output_ok_flag)
        else $error("output ok not restored");
    a_lock_gates: assert property ( // RULE7
        (state_r == S_LOCK)[*3]
        |-> !high_side_gate_cmd && low_side_gate_cmd)
        else $error("gates not forced in lockout");
    a_lock_dump: assert property ( // RULE8
        state_r == S_LOCK ##1 state_r != S_SOFT |-> ss_discharge)
        else $error("soft start not emptied in lockout");
    a_cl_low_side: assert property ( // RULE9
        $rose(cl_r) |-> $past(low_side_gate_cmd))
        else $error("limit taken with low side off");
    a_cl_gates: assert property ( // RULE10
        cl_r[*3] |-> !high_side_gate_cmd)
        else $error("high side on in current limit");
    a_cl_sink: assert property ( // RULE11
        cl_r |=> ss_sink && !ss_charge)
        else $error("no sink in current limit");
    a_duty_cap: assert property ( // RULE12
        active |-> duty_eff <= ss_lvl_r)
        else $error("duty above soft-start level");
    a_blank_cl: assert property ( // RULE13
        pwm_blank && !cl_r |=> !cl_r)
        else $error("limit taken in blanking");
    a_latch_hold: assert property ( // RULE14
        state_r == S_LATCH && cmp_r.shutdown_n && !lockout_r
        |=> state_r == S_LATCH)
        else $error("latch left without shutdown");
    a_first_mask: assert property ( // RULE15
        first_r && state_r == S_SOFT && cmp_r.under_v
        && !cmp_r.over_v && on_req && !lockout_r
        |=> state_r != S_LATCH)
        else $error("under voltage not masked");
    a_nolatch_run: assert property ( // RULE16
        !latch_mode_r && state_r == S_RUN && on_req && !lockout_r
        |=> state_r == S_RUN)
        else $error("non-latching run stopped");
    a_sd_dump: assert property ( // RULE17
        (state_r == S_OFF)[*3] |-> ss_discharge && !high_side_gate_cmd)
        else $error("shutdown not honoured");
    a_period_span: assert property ( // RULE19
        period_r >= `PER_MIN && period_r <= `PER_MAX)
        else $error("period out of range");

    c_reach_run: cover property (state_r == S_SOFT ##1 state_r == S_RUN);
    c_latch: cover property (state_r == S_RUN ##1 state_r == S_LATCH);
    c_climit: cover property ($rose(cl_r));
    c_resume: cover property ($fell(cl_r) ##[1:50] high_side_gate_cmd);
endmodule
`default_nettype wire

// File: src/buck_seq_params.svh
`ifndef BUCK_SEQ_PARAMS_SVH
`define BUCK_SEQ_PARAMS_SVH

// clock and switching range
`define CLK_NS 20
`define CLK_KHZ 50000
`define FSW_MIN_KHZ 50
`define FSW_MAX_KHZ 2000
`define FSW_RST_KHZ 300
`define PER_MAX (`CLK_KHZ / `FSW_MIN_KHZ)
`define PER_MIN (`CLK_KHZ / `FSW_MAX_KHZ)
`define PER_RST (`CLK_KHZ / `FSW_RST_KHZ)

// sense blanking after the high side turns off, rounded up
`define BLANK_NS 100
`define BLANK_CYC ((`BLANK_NS + `CLK_NS - 1) / `CLK_NS)

// register byte offsets
`define A_CTRL 8'h00
`define A_PERIOD 8'h04
`define A_DUTY 8'h08
`define A_STATUS 8'h0C

// fields and reset values
`define CTRL_LATCH_BIT 0
`define CTRL_RST 32'h0000_0001
`define DUTY_RST 32'h0000_0050

`endif

// File: src/buck_seq_pkg.sv
`default_nettype none
package buck_seq_pkg;

    typedef enum logic [2:0] {
        S_LOCK,
        S_OFF,
        S_SOFT,
        S_RUN,
        S_LATCH
    } seq_state_type;

    typedef struct packed {
        logic supply_on;
        logic supply_low;
        logic enable;
        logic shutdown_n;
        logic over_v;
        logic under_v;
        logic cs_over;
        logic ss_full;
    } cmp_type;

endpackage
`default_nettype wire

// File: src/pwm_core.sv
`default_nettype none
module pwm_core
#(
    parameter int PW    = 10,
    parameter int BLANK = 5
)
(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          run,
    input  wire logic          force_low,
    input  wire logic [PW-1:0] period,
    input  wire logic [PW-1:0] duty,
    output var  logic          hs_on,
    output var  logic          period_start,
    output var  logic          blank
);
    logic [PW-1:0] cnt_r;
    logic [7:0]    blank_cnt_r;
    logic          hs_nxt;

    generate
        if (BLANK > 255)
            $error("BLANK too large");
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (!run || cnt_r >= period - 1'b1)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + 1'b1;
    end

    assign period_start = run && (cnt_r == '0);
    assign hs_nxt = run && !force_low && (cnt_r < duty);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hs_on <= 1'b0;
        else
            hs_on <= hs_nxt;
    end

    // diode conduction after the swap would look like a huge current
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            blank_cnt_r <= '0;
        else if (hs_on && !hs_nxt)
            blank_cnt_r <= 8'(BLANK);
        else if (blank_cnt_r != '0)
            blank_cnt_r <= blank_cnt_r - 1'b1;
    end

    assign blank = (blank_cnt_r != '0) || (hs_on && !hs_nxt);
endmodule
`default_nettype wire

// File: verif/fet_stage_model.sv
`default_nettype none
module fet_stage_model
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic high_on,
    input  wire logic low_on,
    input  wire logic overload,
    output var  logic sense_trip
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] diode_cnt;
    logic       low_d;

    // body diode spike
    // the drop reads high for two cycles after every low side turn-on,
    // so a design that does not blank the swap sees a false trip
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_d     <= 1'b1;
            diode_cnt <= 2'd0;
        end
        else
        begin
            low_d     <= low_on;
            diode_cnt <= (low_on && !low_d) ? 2'd1 :
                         (diode_cnt != 2'd0) ? diode_cnt - 2'd1 : 2'd0;
        end
    end

    // drop only exists while low side conducts
    assign sense_trip = low_on && !high_on
                        && (overload || !low_d || diode_cnt != 2'd0);
endmodule
`default_nettype wire

// File: verif/testbench.sv
`include "buck_seq_params.svh"
`default_nettype none
module testbench
    import buck_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SS_TOP = 300;

    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        supply_above_on, supply_below_off, enable_input;
    logic        shutdown_n_input, over_voltage_protect, under_voltage_protect;
    logic        current_sense_input, ss_level_reached, overload, sink_seen;
    logic        high_side_gate_cmd, low_side_gate_cmd, ss_charge;
    logic        ss_discharge, ss_sink, output_ok_flag, output_ok_pull_oe;
    int          err_total, tests_run, ss_cnt, seed, duty, hi_cnt, i;
    int unsigned regm [4];
    int unsigned vals [4];

    assign hready = hreadyout;

    buck_fault_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .supply_above_on(supply_above_on),
        .supply_below_off(supply_below_off), .enable_input(enable_input),
        .shutdown_n_input(shutdown_n_input),
        .over_voltage_protect(over_voltage_protect),
        .under_voltage_protect(under_voltage_protect),
        .current_sense_input(current_sense_input),
        .ss_level_reached(ss_level_reached),
        .high_side_gate_cmd(high_side_gate_cmd),
        .low_side_gate_cmd(low_side_gate_cmd), .ss_charge(ss_charge),
        .ss_discharge(ss_discharge), .ss_sink(ss_sink),
        .output_ok_flag(output_ok_flag),
        .output_ok_pull_oe(output_ok_pull_oe));

    fet_stage_model fet_u (.clk(hclk), .rst_n(hresetn),
        .high_on(high_side_gate_cmd), .low_on(low_side_gate_cmd),
        .overload(overload), .sense_trip(current_sense_input));

    // soft-start node image: charge, dump and sink move the level
    always @(posedge hclk)
    begin
        if (ss_discharge === 1'b1)
            ss_cnt = 0;
        else if (ss_sink === 1'b1 && ss_cnt > 0)
            ss_cnt = ss_cnt - 1;
        else if (ss_charge === 1'b1 && ss_cnt < SS_TOP)
            ss_cnt = ss_cnt + 1;
        ss_level_reached <= (ss_cnt >= SS_TOP);
        if (ss_sink === 1'b1 && !overload)
            sink_seen <= 1'b1;
    end

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic bus_wait;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_total++;
            test_done();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        haddr  <= {24'h0000_00, a};
        bus_wait();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        bus_wait();
        rd = hrdata;
    endtask

    // register model: clamp on write, unmapped ignored
    task automatic wr(input logic [7:0] a, input int unsigned d);
        ahb(1'b1, a, d, rdv);
        case (a)
            `A_CTRL:   regm[0] = d & 1;
            `A_PERIOD: regm[1] = d < `PER_MIN ? `PER_MIN :
                                 d > `PER_MAX ? `PER_MAX : d;
            `A_DUTY:   regm[2] = d > `PER_MAX ? `PER_MAX : d;
            default:   ;
        endcase
    endtask

    task automatic poll(input logic [7:0] mask, input logic [7:0] val);
        int n;
        n = 0;
        do
        begin
            ahb(1'b0, `A_STATUS, 32'h0000_0000, rdv);
            n++;
        end
        while ((rdv[7:0] & mask) !== val && n < 400);
        if ((rdv[7:0] & mask) !== val)
        begin
            err_total++;
            test_done();
        end
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask

    function automatic logic [7:0] st(input seq_state_type s);
        return {s, 5'b0_0000};
    endfunction

    task automatic forced;
        chk("high gate", 32'(high_side_gate_cmd), 32'h0000_0000);
        chk("low gate", 32'(low_side_gate_cmd), 32'h0000_0001);
    endtask

    initial
    begin
        err_total = 0;
        tests_run = 0;
        ss_cnt = 0;
        seed = 32'heae1;
        sink_seen = 1'b0;
        overload = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        supply_above_on = 1'b0;
        supply_below_off = 1'b1;
        enable_input = 1'b1;
        shutdown_n_input = 1'b1;
        over_voltage_protect = 1'b0;
        under_voltage_protect = 1'b1;
        ss_level_reached = 1'b0;
        regm = '{`CTRL_RST, `PER_RST, `DUTY_RST, 0};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        forced();
        chk("dump", 32'(ss_discharge), 32'h0000_0001);
        chk("pull", 32'(output_ok_pull_oe), 32'h0000_0001);
        vals = '{10, 2000, {$random(seed)} % 1100, {$random(seed)} % 1100};
        for (i = 0; i < 7; i++)
        begin
            if (i > 2)
                wr(`A_PERIOD, vals[i-3]);
            ahb(1'b0, 8'(i > 2 ? 1 : i) << 2, 32'h0000_0000, rdv);
            chk("register", rdv, regm[i > 2 ? 1 : i]);
        end
        wr(8'h10, 32'h0000_00ff);
        ahb(1'b0, 8'h10, 32'h0000_0000, rdv);
        chk("unmapped", rdv, 32'h0000_0000);
        chk("resp", 32'(hresp), 32'h0000_0000);
        $display("test registers done");

        supply_below_off <= 1'b0;
        supply_above_on <= 1'b1;
        poll(8'he0, st(S_SOFT));
        chk("charge", 32'(ss_charge), 32'h0000_0001);
        chk("flag soft", 32'(output_ok_flag), 32'h0000_0000);
        chk("ramp state", 32'(rdv[7:5]), 32'(S_SOFT));
        under_voltage_protect <= 1'b0;
        poll(8'he0, st(S_RUN));
        chk("flag run", 32'(output_ok_flag), 32'h0000_0001);
        chk("pull run", 32'(output_ok_pull_oe), 32'h0000_0000);
        $display("test start done");

        duty = 5 + {$random(seed)} % 30;
        wr(`A_PERIOD, 40);
        wr(`A_DUTY, duty);
        repeat (1600) @(posedge hclk);
        hi_cnt = 0;
        for (i = 0; i < 160; i++)
        begin
            @(negedge hclk);
            hi_cnt += int'(high_side_gate_cmd === 1'b1);
            chk("complement", 32'(low_side_gate_cmd),
                32'(!high_side_gate_cmd));
        end
        chk("duty", 32'(hi_cnt), 32'(4 * duty));
        chk("blank", 32'(sink_seen), 32'h0000_0000);
        $display("test duty done");

        over_voltage_protect <= 1'b1;
        poll(8'he0, st(S_LATCH));
        forced();
        chk("flag ov", 32'(output_ok_flag), 32'h0000_0000);
        chk("latch dump", 32'(ss_discharge), 32'h0000_0001);
        over_voltage_protect <= 1'b0;
        repeat (30) @(posedge hclk);
        ahb(1'b0, `A_STATUS, 32'h0000_0000, rdv);
        chk("held", 32'(rdv[7:5]), 32'(S_LATCH));
        shutdown_n_input <= 1'b0;
        poll(8'he0, st(S_OFF));
        forced();
        chk("sd dump", 32'(ss_discharge), 32'h0000_0001);
        shutdown_n_input <= 1'b1;
        poll(8'he0, st(S_RUN));
        $display("test latch done");

        wr(`A_CTRL, 0);
        ahb(1'b0, `A_CTRL, 32'h0000_0000, rdv);
        chk("ctrl", rdv, regm[0]);
        under_voltage_protect <= 1'b1;
        poll(8'h04, 8'h00);
        forced();
        chk("flag uv", 32'(output_ok_pull_oe), 32'h0000_0001);
        under_voltage_protect <= 1'b0;
        poll(8'h04, 8'h04);
        chk("flag back", 32'(output_ok_flag), 32'h0000_0001);
        chk("resume", 32'(rdv[7:5]), 32'(S_RUN));
        $display("test nonlatch done");

        overload <= 1'b1;
        poll(8'h08, 8'h08);
        forced();
        chk("sink", 32'(ss_sink), 32'h0000_0001);
        hi_cnt = 0;
        for (i = 0; i < 80; i++)
        begin
            @(negedge hclk);
            hi_cnt += int'(high_side_gate_cmd !== 1'b0);
        end
        chk("limit high", 32'(hi_cnt), 32'h0000_0000);
        overload <= 1'b0;
        poll(8'h08, 8'h00);
        $display("test limit done");

        supply_above_on <= 1'b0;
        supply_below_off <= 1'b1;
        poll(8'he0, st(S_LOCK));
        forced();
        chk("lock dump", 32'(ss_discharge), 32'h0000_0001);
        chk("lock flag", 32'(output_ok_flag), 32'h0000_0000);
        wr(`A_CTRL, 1);
        under_voltage_protect <= 1'b1;
        supply_below_off <= 1'b0;
        supply_above_on <= 1'b1;
        poll(8'he0, st(S_LATCH));
        chk("second ramp", 32'(rdv[7:5]), 32'(S_LATCH));
        under_voltage_protect <= 1'b0;
        shutdown_n_input <= 1'b0;
        poll(8'he0, st(S_OFF));
        shutdown_n_input <= 1'b1;
        poll(8'he0, st(S_RUN));
        $display("test lockout done");
        test_done();
    end
endmodule
`default_nettype wire
